// ===== rtl/cps_sequencer.sv
// Phase sequencer, threshold adaptation and output protocol of the crank speed sensor
//
// How it works
// - Power-on loads configuration, initialises state, output held high.
// - Power-on lasts 0.9 ms with output held high throughout.
// - Configuration error at load locks the output high for good.
// - Initial phase lasts exactly one clock, then first calibration.
// - Initial phase enables switching, extrema detection and adaptation permanently.
// - First calibration ends after 3 edges, at most 4, then second.
// - First calibration sets the threshold quickly to measured midpoint.
// - Extrema state machine tracks minima and maxima feeding adaptation.
// - First two switchings on sufficient field change, of configured polarity except in profile mode.
// - Third and later switchings at speed signal zero crossing.
// - Zero level is midpoint between detected minimum and maximum.
// - Pulse width from direction value sampled at zero crossing.
// - Very first pulse always uses forward width.
// - Second calibration lasts 5 to 58 teeth per algorithm, then running.
// - Second calibration adapts threshold slowly and accurately.
// - Running phase averages 5 to 58 pulses per offset update.
// - Running persists forever, filtering threshold updates.
// - Running output follows threshold, hidden hysteresis and protocol.
// - Forward pulse 45 us, backward 90 us or optional 135 us.
// - Profile mode output toggles at each tooth and notch middle.
// - Field to output polarity mapping selected by configuration.
// - Speed and direction channels arrive as digitised samples.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "cps_regs.svh"

module cps_sequencer #(
    parameter int W = 12,
    parameter int POWER_ON_CYCLES = `CPS_POWER_ON_NS / `CPS_CLK_PERIOD_NS,
    parameter int FWD_CYCLES = `CPS_FWD_NS / `CPS_CLK_PERIOD_NS,
    parameter int BWD_STD_CYCLES = `CPS_BWD_STD_NS / `CPS_CLK_PERIOD_NS,
    parameter int BWD_OPT_CYCLES = `CPS_BWD_OPT_NS / `CPS_CLK_PERIOD_NS,
    parameter int HYS_MIN = 8,
    parameter int DNC_STEP = 4,
    parameter int MIN_UPDATE = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic nvm_error,
    input wire logic signed [W-1:0] speed_sample,
    input wire logic signed [W-1:0] dir_sample,
    input wire logic sample_valid,
    output logic q_out,
    output logic [2:0] phase_out
);
    localparam int WE = W + 2;
    localparam int WA = W + 8;
    localparam int CW = 24;

    // Parameters the logic cannot serve
    if (W < 4 || W > 16 || POWER_ON_CYCLES < 1 || FWD_CYCLES < 1 || BWD_STD_CYCLES < 1
        || BWD_OPT_CYCLES < 1 || POWER_ON_CYCLES >= (1 << CW) || BWD_OPT_CYCLES >= (1 << CW)
        || HYS_MIN < 0 || DNC_STEP < 1 || MIN_UPDATE < 0) begin : g_bad_param
        $error("cps_sequencer: unsupported parameter value");
    end

    cps_pkg::cps_phase_e phase_reg;
    cps_pkg::cps_ext_e ext_reg;
    logic [7:0] cfg_reg;
    logic [7:0] act_cfg_reg;
    logic nvm_meta_reg, nvm_sync_reg;
    logic [CW-1:0] por_cnt_reg;
    logic enable_reg;
    logic signed [W-1:0] max_reg, min_reg, peak_max_reg, peak_min_reg, thr_reg;
    logic [1:0] peaks_seen_reg;
    logic [2:0] edge_cnt_reg;
    logic [6:0] tooth_cnt_reg;
    logic [1:0] sw_cnt_reg;
    logic above_reg, armed_up_reg, armed_dn_reg;
    logic signed [W-1:0] dir_a_reg;
    logic dir_a_seen_reg, dir_valid_reg, backward_reg;
    logic signed [WA-1:0] acc_reg;
    logic [5:0] avg_cnt_reg;
    logic last_err_neg_reg, last_upd_neg_reg, opp_pend_reg;
    logic [CW-1:0] pulse_cnt_reg;
    logic q_reg;
    logic [31:0] rdata_reg;

    // Active configuration fields
    cps_pkg::cps_proto_e proto;
    wire edge_polar = act_cfg_reg[`CPS_CFG_EDGE_POLAR_BIT];
    wire forward_def = act_cfg_reg[`CPS_CFG_FORWARD_DEF_BIT];
    wire [1:0] alg = act_cfg_reg[`CPS_CFG_ALG_MSB:`CPS_CFG_ALG_LSB];
    wire [1:0] dnc_sel = act_cfg_reg[`CPS_CFG_DNC_MSB:`CPS_CFG_DNC_LSB];
    assign proto = cps_pkg::cps_proto_e'(act_cfg_reg[`CPS_CFG_PROTO_MSB:`CPS_CFG_PROTO_LSB]);
    wire profile_mode = (proto == cps_pkg::CPS_PROTO_PROFILE);
    wire [6:0] alg_teeth = (alg == 2'h0) ? 7'(`CPS_ALG0_TEETH) :
                           (alg == 2'h1) ? 7'(`CPS_ALG1_TEETH) : 7'(`CPS_ALG2_TEETH);

    // Phase decode
    wire in_power_on = (phase_reg == cps_pkg::CPS_POWER_ON);
    wire in_cal1 = (phase_reg == cps_pkg::CPS_CAL1);
    wire in_cal2 = (phase_reg == cps_pkg::CPS_CAL2);
    wire in_run = (phase_reg == cps_pkg::CPS_RUNNING);
    wire locked = (phase_reg == cps_pkg::CPS_LOCKED);
    wire por_done = (por_cnt_reg == CW'(POWER_ON_CYCLES - 1));
    wire active = enable_reg && !locked;

    // Sample arithmetic on the digitised channels
    wire signed [WE-1:0] s_e = WE'(speed_sample);
    wire signed [WE-1:0] max_e = WE'(max_reg);
    wire signed [WE-1:0] min_e = WE'(min_reg);
    wire signed [WE-1:0] thr_e = WE'(thr_reg);
    wire signed [WE-1:0] pkpk = WE'(peak_max_reg) - WE'(peak_min_reg);
    wire signed [WE-1:0] hys_adapt = pkpk >>> 2;
    wire signed [WE-1:0] hys_run = (hys_adapt > WE'(HYS_MIN)) ? hys_adapt : WE'(HYS_MIN);
    wire signed [WE-1:0] dnc = WE'(DNC_STEP) <<< dnc_sel;
    wire signed [WE-1:0] hyst = (in_run || in_cal2) ? hys_run : dnc;
    wire smp = sample_valid && active;
    wire new_max = smp && (ext_reg == cps_pkg::CPS_SEEK_MAX) && (s_e > max_e);
    wire new_min = smp && (ext_reg == cps_pkg::CPS_SEEK_MIN) && (s_e < min_e);
    wire edge_fall = smp && (ext_reg == cps_pkg::CPS_SEEK_MAX) && (s_e < max_e - hyst);
    wire edge_rise = smp && (ext_reg == cps_pkg::CPS_SEEK_MIN) && (s_e > min_e + hyst);
    wire any_edge = edge_fall || edge_rise;

    // Midpoint of the last extrema serves as the zero level
    wire signed [W:0] peak_sum = (W+1)'(peak_max_reg) + (W+1)'(peak_min_reg);
    wire signed [W-1:0] mid = W'(peak_sum >>> 1);
    wire both_peaks = (peaks_seen_reg == 2'h3);

    // Zero crossing against the threshold with hidden hysteresis arming
    wire above_now = (s_e > thr_e);
    wire cross_up = smp && above_now && !above_reg && armed_up_reg;
    wire cross_dn = smp && !above_now && above_reg && armed_dn_reg;
    wire early = (sw_cnt_reg < 2'(`CPS_FIRST_ZC_SWITCH));
    wire ev_early = profile_mode ? any_edge : (edge_polar ? edge_rise : edge_fall);
    wire ev_zc = profile_mode ? (cross_up || cross_dn)
                              : (edge_polar ? cross_up : cross_dn);
    wire sw_event = early ? ev_early : ev_zc;
    wire sw_rising = early ? edge_rise : cross_up;
    wire other_zc = edge_polar ? cross_dn : cross_up;

    // Direction from the difference of two direction samples per period
    wire signed [W:0] dir_diff = (W+1)'(dir_a_reg) - (W+1)'(dir_sample);
    wire dir_backward_now = dir_valid_reg && ((dir_diff < 0) ^ forward_def);
    wire [CW-1:0] bwd_cycles = (proto == cps_pkg::CPS_PROTO_OPT) ? CW'(BWD_OPT_CYCLES)
                                                                 : CW'(BWD_STD_CYCLES);
    wire [CW-1:0] width = dir_backward_now ? bwd_cycles : CW'(FWD_CYCLES);

    // Offset update averaging in the running phase
    wire signed [WA-1:0] err = WA'(mid) - WA'(thr_reg);
    wire err_neg = (err < 0);
    wire sign_break = (alg == 2'h2) && (avg_cnt_reg != 6'h0) && (err_neg != last_err_neg_reg);
    wire signed [WA-1:0] acc_sum = (sign_break ? WA'(0) : acc_reg) + err;
    wire [5:0] avg_cnt_inc = sign_break ? 6'h1 : avg_cnt_reg + 6'h1;
    wire avg_full = (avg_cnt_inc == alg_teeth[5:0]);
    wire signed [WA-1:0] avg = (alg == 2'h0) ? acc_sum / WA'(`CPS_ALG0_TEETH) :
                               (alg == 2'h1) ? acc_sum / WA'(`CPS_ALG1_TEETH) :
                                               acc_sum / WA'(`CPS_ALG2_TEETH);
    wire signed [WA-1:0] upd = avg >>> 1;
    wire upd_neg = (upd < 0);
    wire signed [WA-1:0] upd_mag = upd_neg ? -upd : upd;
    wire upd_big = (upd_mag >= WA'(MIN_UPDATE)) && (upd != 0);
    wire upd_opposite = (upd_neg != last_upd_neg_reg);
    wire run_tick = in_run && edge_fall;
    wire upd_apply = run_tick && avg_full && upd_big && (!upd_opposite || opp_pend_reg);
    wire signed [WE-1:0] slow_step = (WE'(mid) - thr_e) >>> 2;

    // Register port decode
    wire sel_cfg = (reg_addr == `CPS_CFG_OFS);
    wire sel_status = (reg_addr == `CPS_STATUS_OFS);
    wire sel_thresh = (reg_addr == `CPS_THRESH_OFS);
    wire sel_peaks = (reg_addr == `CPS_PEAKS_OFS);
    wire [31:0] status_word = {26'h0, dir_valid_reg, q_reg, backward_reg, phase_reg};
    wire [31:0] rdata_next = sel_cfg ? {24'h0, cfg_reg} :
                             sel_status ? status_word :
                             sel_thresh ? {{(32-W){1'b0}}, thr_reg} :
                             sel_peaks ? {{(16-W){1'b0}}, peak_max_reg,
                                          {(16-W){1'b0}}, peak_min_reg} : 32'h0;

    // Error pin synchroniser
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nvm_meta_reg <= 1'b0;
            nvm_sync_reg <= 1'b0;
        end else begin
            nvm_meta_reg <= nvm_error;
            nvm_sync_reg <= nvm_meta_reg;
        end
    end

    // Register port: configuration image and read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= `CPS_CFG_RESET;
            rdata_reg <= 32'h0;
        end else begin
            if (reg_wr && sel_cfg) begin
                cfg_reg <= reg_wdata[7:0];
            end
            rdata_reg <= reg_rd ? rdata_next : 32'h0;
        end
    end

    // Power-on timer and configuration load
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt_reg <= '0;
            act_cfg_reg <= `CPS_CFG_RESET;
        end else if (in_power_on) begin
            por_cnt_reg <= por_cnt_reg + CW'(1);
            if (por_done) begin
                act_cfg_reg <= cfg_reg;
            end
        end
    end

    // Phase state machine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= cps_pkg::CPS_POWER_ON;
            enable_reg <= 1'b0;
        end else begin
            case (phase_reg)
                cps_pkg::CPS_POWER_ON: begin
                    if (por_done) begin
                        phase_reg <= nvm_sync_reg ? cps_pkg::CPS_LOCKED
                                                  : cps_pkg::CPS_INITIAL;
                    end
                end
                cps_pkg::CPS_INITIAL: begin
                    enable_reg <= 1'b1;
                    phase_reg <= cps_pkg::CPS_CAL1;
                end
                cps_pkg::CPS_CAL1: begin
                    if (any_edge && ((edge_cnt_reg + 3'h1 == 3'(`CPS_CAL1_EDGES) && both_peaks)
                        || edge_cnt_reg + 3'h1 == 3'(`CPS_CAL1_EDGES_MAX))) begin
                        phase_reg <= cps_pkg::CPS_CAL2;
                    end
                end
                cps_pkg::CPS_CAL2: begin
                    if (edge_fall && tooth_cnt_reg + 7'h1 >= alg_teeth) begin
                        phase_reg <= cps_pkg::CPS_RUNNING;
                    end
                end
                cps_pkg::CPS_RUNNING: phase_reg <= cps_pkg::CPS_RUNNING;
                cps_pkg::CPS_LOCKED: phase_reg <= cps_pkg::CPS_LOCKED;
                default: phase_reg <= cps_pkg::CPS_LOCKED;
            endcase
        end
    end

    // Edge and tooth counters of the calibration phases
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_cnt_reg <= 3'h0;
            tooth_cnt_reg <= 7'h0;
        end else begin
            if (in_cal1 && any_edge) begin
                edge_cnt_reg <= edge_cnt_reg + 3'h1;
            end
            if (in_cal2 && edge_fall) begin
                tooth_cnt_reg <= tooth_cnt_reg + 7'h1;
            end
        end
    end

    // Extrema detection state machine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_reg <= cps_pkg::CPS_SEEK_MAX;
            max_reg <= '0;
            min_reg <= '0;
            peak_max_reg <= '0;
            peak_min_reg <= '0;
            peaks_seen_reg <= 2'h0;
        end else if (edge_fall) begin
            ext_reg <= cps_pkg::CPS_SEEK_MIN;
            peak_max_reg <= max_reg;
            min_reg <= speed_sample;
            peaks_seen_reg <= peaks_seen_reg | 2'h2;
        end else if (edge_rise) begin
            ext_reg <= cps_pkg::CPS_SEEK_MAX;
            peak_min_reg <= min_reg;
            max_reg <= speed_sample;
            peaks_seen_reg <= peaks_seen_reg | 2'h1;
        end else if (new_max) begin
            max_reg <= speed_sample;
        end else if (new_min) begin
            min_reg <= speed_sample;
        end
    end

    // Threshold adaptation: fast, slow, then averaged and filtered
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_reg <= '0;
        end else if (in_cal1 && any_edge && both_peaks) begin
            thr_reg <= mid;
        end else if (in_cal2 && any_edge) begin
            thr_reg <= W'(thr_e + slow_step);
        end else if (upd_apply) begin
            thr_reg <= W'(WA'(thr_reg) + upd);
        end
    end

    // Averaging accumulator and update filter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= '0;
            avg_cnt_reg <= 6'h0;
            last_err_neg_reg <= 1'b0;
            last_upd_neg_reg <= 1'b0;
            opp_pend_reg <= 1'b0;
        end else if (run_tick) begin
            last_err_neg_reg <= err_neg;
            acc_reg <= avg_full ? WA'(0) : acc_sum;
            avg_cnt_reg <= avg_full ? 6'h0 : avg_cnt_inc;
            if (avg_full && upd_big) begin
                if (upd_opposite && !opp_pend_reg) begin
                    opp_pend_reg <= 1'b1;
                end else begin
                    opp_pend_reg <= 1'b0;
                    last_upd_neg_reg <= upd_neg;
                end
            end
        end
    end

    // Crossing tracker with hidden hysteresis arming
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            above_reg <= 1'b0;
            armed_up_reg <= 1'b0;
            armed_dn_reg <= 1'b0;
        end else if (smp) begin
            above_reg <= above_now;
            armed_up_reg <= cross_up ? 1'b0 : (armed_up_reg || s_e < thr_e - hyst);
            armed_dn_reg <= cross_dn ? 1'b0 : (armed_dn_reg || s_e > thr_e + hyst);
        end
    end

    // Direction samples taken at the speed zero crossings
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_a_reg <= '0;
            dir_a_seen_reg <= 1'b0;
            dir_valid_reg <= 1'b0;
            backward_reg <= 1'b0;
        end else begin
            if (other_zc) begin
                dir_a_reg <= dir_sample;
                dir_a_seen_reg <= 1'b1;
            end
            if (sw_event && !profile_mode) begin
                backward_reg <= dir_backward_now;
                dir_valid_reg <= dir_a_seen_reg;
            end
        end
    end

    // Switching count and output generation
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_cnt_reg <= 2'h0;
            pulse_cnt_reg <= '0;
            q_reg <= 1'b1;
        end else if (!active) begin
            q_reg <= 1'b1;
        end else if (sw_event) begin
            if (early) begin
                sw_cnt_reg <= sw_cnt_reg + 2'h1;
            end
            if (profile_mode) begin
                q_reg <= sw_rising ^ edge_polar;
            end else begin
                q_reg <= 1'b0;
                pulse_cnt_reg <= width - CW'(1);
            end
        end else if (!profile_mode && !q_reg) begin
            if (pulse_cnt_reg == '0) begin
                q_reg <= 1'b1;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg - CW'(1);
            end
        end
    end

    // Outputs straight from flip-flops
    assign q_out = q_reg;
    assign phase_out = phase_reg;
    assign reg_rdata = rdata_reg;

endmodule
`default_nettype wire

// ===== inc/cps_regs.svh
// Register offsets, field positions, reset values and timing figures of the sequencer
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// Register byte offsets
`define CPS_CFG_OFS 4'h0
`define CPS_STATUS_OFS 4'h4
`define CPS_THRESH_OFS 4'h8
`define CPS_PEAKS_OFS 4'hc

// Configuration word fields
`define CPS_CFG_PROTO_LSB 0
`define CPS_CFG_PROTO_MSB 1
`define CPS_CFG_EDGE_POLAR_BIT 2
`define CPS_CFG_FORWARD_DEF_BIT 3
`define CPS_CFG_ALG_LSB 4
`define CPS_CFG_ALG_MSB 5
`define CPS_CFG_DNC_LSB 6
`define CPS_CFG_DNC_MSB 7
`define CPS_CFG_RESET 8'h01

// Status and peaks word fields
`define CPS_ST_PHASE_LSB 0
`define CPS_ST_PHASE_MSB 2
`define CPS_ST_BACKWARD_BIT 3
`define CPS_ST_OUT_BIT 4
`define CPS_ST_DIR_VALID_BIT 5
`define CPS_PEAKS_MAX_LSB 16

// Timing figures
`define CPS_CLK_PERIOD_NS 10
`define CPS_POWER_ON_NS 900000
`define CPS_FWD_NS 45000
`define CPS_BWD_STD_NS 90000
`define CPS_BWD_OPT_NS 135000

// Edge and tooth counts
`define CPS_CAL1_EDGES 3
`define CPS_CAL1_EDGES_MAX 4
`define CPS_ALG0_TEETH 58
`define CPS_ALG1_TEETH 32
`define CPS_ALG2_TEETH 5
`define CPS_FIRST_ZC_SWITCH 2

`endif

// ===== inc/cps_pkg.sv
// Types shared by the crank pulse phase sequencer
package cps_pkg;

    typedef enum logic [2:0] {
        CPS_POWER_ON = 3'h0,
        CPS_INITIAL = 3'h1,
        CPS_CAL1 = 3'h2,
        CPS_CAL2 = 3'h3,
        CPS_RUNNING = 3'h4,
        CPS_LOCKED = 3'h5
    } cps_phase_e;

    typedef enum logic {
        CPS_SEEK_MAX = 1'h0,
        CPS_SEEK_MIN = 1'h1
    } cps_ext_e;

    typedef enum logic [1:0] {
        CPS_PROTO_PROFILE = 2'h0,
        CPS_PROTO_STD = 2'h1,
        CPS_PROTO_OPT = 2'h2
    } cps_proto_e;

endpackage

// ===== dv/cps_sequencer_assertions.sv
// Checker of phase order, output timing and read port of the sequencer
`timescale 1ns/10ps
`default_nettype none
module cps_sequencer_checker #(
    parameter int POWER_ON_CYCLES = 90000,
    parameter int FWD_CYCLES = 4500,
    parameter int BWD_STD_CYCLES = 9000,
    parameter int BWD_OPT_CYCLES = 13500
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic q_out,
    input wire logic [2:0] phase_out
);
    int pwr_cnt;
    int lo_cnt;
    logic seen_pulse;
    logic [1:0] proto_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Power-on length, low-time length, first pulse flag, protocol copy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_cnt <= 0;
            lo_cnt <= 0;
            seen_pulse <= 1'b0;
            proto_q <= 2'h1;
        end else begin
            pwr_cnt <= (phase_out == 3'h0) ? pwr_cnt + 1 : pwr_cnt;
            lo_cnt <= q_out ? 0 : lo_cnt + 1;
            seen_pulse <= seen_pulse | (q_out && lo_cnt != 0);
            proto_q <= (reg_wr && reg_addr == 4'h0) ? reg_wdata[1:0] : proto_q;
        end
    end
    // Phase sequence
    property p_pwr_high; phase_out == 3'h0 |-> q_out; endproperty
    a_pwr_high: assert property (p_pwr_high) else $error("output low in power-on");
    property p_pwr_len;
        $past(phase_out) == 3'h0 && phase_out != 3'h0
            |-> pwr_cnt inside {[POWER_ON_CYCLES - 2:POWER_ON_CYCLES + 2]};
    endproperty
    a_pwr_len: assert property (p_pwr_len) else $error("power-on length off");
    property p_locked; phase_out == 3'h5 |=> phase_out == 3'h5 && q_out; endproperty
    a_locked: assert property (p_locked) else $error("locked state left");
    property p_init_one; phase_out == 3'h1 |=> phase_out == 3'h2; endproperty
    a_init_one: assert property (p_init_one) else $error("initial not one cycle");
    property p_order;
        $changed(phase_out) |-> phase_out == 3'($past(phase_out) + 3'h1)
            || ($past(phase_out) == 3'h0 && phase_out == 3'h5);
    endproperty
    a_order: assert property (p_order) else $error("illegal phase step");
    property p_run_stay; phase_out == 3'h4 |=> phase_out == 3'h4; endproperty
    a_run_stay: assert property (p_run_stay) else $error("running left");
    // Pulse widths, causes and idle read data
    property p_width;
        $rose(q_out) && proto_q != 2'h0 |-> lo_cnt == FWD_CYCLES
            || lo_cnt == (proto_q == 2'h2 ? BWD_OPT_CYCLES : BWD_STD_CYCLES);
    endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");
    property p_first_fwd; $rose(q_out) && !seen_pulse && proto_q != 2'h0 |-> lo_cnt == FWD_CYCLES;
    endproperty
    a_first_fwd: assert property (p_first_fwd) else $error("first pulse not forward");
    property p_fall_cause; $fell(q_out) |-> $past(sample_valid); endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("fall without sample");
    property p_prof_cause; $rose(q_out) && proto_q == 2'h0 |-> $past(sample_valid); endproperty
    a_prof_cause: assert property (p_prof_cause) else $error("profile rise uncaused");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
    // Main scenarios reached
    c_running: cover property (phase_out == 3'h4);
    c_locked: cover property (phase_out == 3'h5);
    c_opt_bwd: cover property ($rose(q_out) && lo_cnt == BWD_OPT_CYCLES);
endmodule
bind cps_sequencer cps_sequencer_checker #(.POWER_ON_CYCLES(POWER_ON_CYCLES),
    .FWD_CYCLES(FWD_CYCLES), .BWD_STD_CYCLES(BWD_STD_CYCLES),
    .BWD_OPT_CYCLES(BWD_OPT_CYCLES)) u_chk (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .q_out, .phase_out);
`default_nettype wire

// ===== dv/cps_ecu_model.sv
// Engine controller model decoding output pulse widths
`timescale 1ns/10ps
`default_nettype none
module cps_ecu_model #(
    parameter int FWD_CYCLES = 5,
    parameter int BWD_STD_CYCLES = 10
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic q_out,
    output logic [15:0] pulse_cnt,
    output logic [15:0] first_width,
    output logic [15:0] last_width,
    output logic last_bwd
);
    logic [15:0] low_cnt;
    logic q_d;
    // Low time measured in clocks, direction told by width
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            {pulse_cnt, first_width, last_width, low_cnt} <= '0;
            last_bwd <= 1'b0;
            q_d <= 1'b1;
        end else begin
            q_d <= q_out;
            low_cnt <= q_out ? 16'h0 : low_cnt + 16'h1;
            if (q_out && !q_d) begin
                pulse_cnt <= pulse_cnt + 16'h1;
                last_width <= low_cnt;
                first_width <= (pulse_cnt == 16'h0) ? low_cnt : first_width;
                last_bwd <= 32'(low_cnt) > (FWD_CYCLES + BWD_STD_CYCLES) / 2;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/crank_pulse_phase_sequencer_tb.sv
// Self-checking bench of the crank pulse phase sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module crank_pulse_phase_sequencer_tb;
    localparam int PON = 50;
    localparam int FWD = 5;
    localparam int BWD = 10;
    localparam int OPT = 15;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nvm_error = 1'b0;
    logic sample_valid = 1'b0;
    logic signed [11:0] speed_sample = 12'h000;
    logic signed [11:0] dir_sample = 12'h000;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    logic q_out;
    logic [2:0] phase_out;
    logic [15:0] pulse_cnt;
    logic [15:0] first_width;
    logic [15:0] last_width;
    logic last_bwd;
    int error_cnt = 0;
    int checks = 0;
    // Clock and units
    always #5 core_clk = ~core_clk;
    cps_sequencer #(.POWER_ON_CYCLES(PON), .FWD_CYCLES(FWD), .BWD_STD_CYCLES(BWD),
        .BWD_OPT_CYCLES(OPT)) dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .nvm_error, .speed_sample, .dir_sample, .sample_valid, .q_out,
        .phase_out);
    cps_ecu_model #(.FWD_CYCLES(FWD), .BWD_STD_CYCLES(BWD)) ecu (.core_clk, .reset_n, .q_out,
        .pulse_cnt, .first_width, .last_width, .last_bwd);
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // Reset, configure in power-on, wait for the first calibration
    task automatic start(input logic [7:0] cfg, input logic err);
        @(posedge core_clk);
        reset_n <= 1'b0;
        nvm_error <= err;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_reg(4'h0);
        `CHK("cfg reset", 32'h01, rd_val)
        wr_reg(4'h0, {24'h0, cfg});
        for (int n = 0; n < 200 && phase_out === 3'h0; n++) begin
            `CHK("power-on level", 1'b1, q_out)
            @(posedge core_clk);
            #1;
        end
        `CHK("phase after power-on", err ? 3'h5 : 3'h1, phase_out)
        @(posedge core_clk);
        #1 `CHK("phase next", err ? 3'h5 : 3'h2, phase_out)
    endtask
    task automatic sample(input logic [11:0] s, input logic [11:0] d);
        @(posedge core_clk);
        speed_sample <= s;
        dir_sample <= d;
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    // Teeth swing 500 and -300, direction values a then b
    task automatic wheel(input int teeth, input logic [11:0] a, input logic [11:0] b);
        repeat (teeth) begin
            repeat (3) sample(12'h1f4, a);
            repeat (3) sample(12'hed4, b);
        end
    endtask
    task automatic sc_lock();
        start(8'h01, 1'b1);
        wheel(2, 12'h000, 12'h000);
        `CHK("locked phase", 3'h5, phase_out)
        `CHK("locked level", 1'b1, q_out)
        `CHK("locked pulses", 16'h0, pulse_cnt)
    endtask
    // Teeth of one direction to running, then reversal; forward only when fdef is 0
    task automatic sc_direction(input logic [1:0] proto, input logic fdef, input int bw);
        start({4'b0010, fdef, 1'b1, proto}, 1'b0);
        wheel(12, 12'hed4, 12'h12c);
        `CHK("first width", 16'(FWD), first_width)
        `CHK("phase", 3'h4, phase_out)
        `CHK("steady width", 16'(fdef ? bw : FWD), last_width)
        rd_reg(4'h8);
        `CHK("threshold", 12'h064, rd_val[11:0])
        rd_reg(4'hc);
        `CHK("peaks", 32'h01f40ed4, rd_val)
        wr_reg(4'h8, 32'hffffffff);
        rd_reg(4'h2);
        `CHK("unmapped", 32'h0, rd_val)
        rd_reg(4'h8);
        `CHK("threshold kept", 12'h064, rd_val[11:0])
        wheel(2, 12'h12c, 12'hed4);
        `CHK("reversed width", 16'(fdef ? FWD : bw), last_width)
        `CHK("decoded backward", ~fdef, last_bwd)
        rd_reg(4'h4);
        `CHK("status", {2'h3, ~fdef, 3'h4}, rd_val[5:0])
    endtask
    // Profile level after low and high teeth for both polarities
    task automatic sc_profile(input logic pol);
        start({5'b00100, pol, 2'h0}, 1'b0);
        wheel(8, 12'h000, 12'h000);
        `CHK("profile after notch", pol, q_out)
        sample(12'h1f4, 12'h000);
        `CHK("profile after tooth", ~pol, q_out)
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        sc_lock();
        sc_direction(2'h1, 1'b0, BWD);
        sc_direction(2'h2, 1'b1, OPT);
        sc_profile(1'b0);
        sc_profile(1'b1);
        conclude();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        $display("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
